// >>> logic/ilc_top.sv
// Two-channel ack handling and internal latch clear, with APB registers and interrupt.
// Assumes an APB master on clock_i and open-drain pins resolved outside.
`timescale 1ns/1ps
module ilc_top (
	input  wire logic                          clock_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          psel_i,
	input  wire logic                          penable_i,
	input  wire logic                          pwrite_i,
	input  wire logic [ilc_pkg::ADDR_W-1:0]    paddr_i,
	input  wire logic [31:0]                   pwdata_i,
	output logic      [31:0]                   prdata_o,
	output logic                               pready_o,
	output logic                               pslverr_o,
	input  wire logic [ilc_pkg::NUM_CH-1:0]    scl_i,
	input  wire logic [ilc_pkg::NUM_CH-1:0]    sda_i,
	output logic      [ilc_pkg::NUM_CH-1:0]    sda_o,
	output logic      [ilc_pkg::NUM_CH-1:0]    sda_oe_o,
	output logic      [ilc_pkg::NUM_CH-1:0]    scl_o,
	output logic      [ilc_pkg::NUM_CH-1:0]    scl_oe_o,
	output logic      [ilc_pkg::NUM_CH-1:0]    chan_clear_o,
	output logic                               irq_o
);
	localparam int NC = ilc_pkg::NUM_CH;

	logic [NC-1:0]            scl_s;
	logic [NC-1:0]            sda_s;
	logic                     wr_en;
	logic                     rd_setup;
	logic                     addr_ok;
	logic [3:0]               clr_code;
	logic [NC-1:0]            clr_sel;
	logic [NC-1:0]            clr_pulse;
	logic [2:0]               lcr_rsvd;
	logic [ilc_pkg::IRQ_W-1:0] irq_stat;
	logic [ilc_pkg::IRQ_W-1:0] irq_mask;
	logic [ilc_pkg::IRQ_W-1:0] irq_set;
	ilc_pkg::ilc_ctrl_t       ctrl [NC];
	ilc_pkg::ilc_evt_t        evt [NC];
	logic [NC-1:0]            ack_sampled;
	logic [NC-1:0]            rx_ready;
	logic [NC-1:0]            wr_ctrl;
	logic [31:0]              next_rdata;

	// Pin synchronisers
	ilc_sync2 #(.W(2 * NC)) u_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.async_i ({scl_i, sda_i}),
		.sync_o  ({scl_s, sda_s})
	);

	// APB decode: zero wait states
	assign wr_en     = psel_i & penable_i & pwrite_i;
	assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
	assign pready_o  = 1'b1;
	assign addr_ok   = paddr_i == ilc_pkg::OFS_CTRL0 || paddr_i == ilc_pkg::OFS_CTRL1
		|| paddr_i == ilc_pkg::OFS_LATCH_CLR || paddr_i == ilc_pkg::OFS_IRQ_STAT
		|| paddr_i == ilc_pkg::OFS_IRQ_MASK;
	assign pslverr_o = psel_i & penable_i & ~addr_ok;
	assign wr_ctrl[0] = wr_en && paddr_i == ilc_pkg::OFS_CTRL0;
	assign wr_ctrl[1] = wr_en && paddr_i == ilc_pkg::OFS_CTRL1;

	// Clear code decode
	assign clr_code = pwdata_i[3:0];
	always_comb begin
		clr_sel = '0;
		if (wr_en && paddr_i == ilc_pkg::OFS_LATCH_CLR) begin
			unique case (clr_code)
				ilc_pkg::CLR_CODE_CH0:  clr_sel = 2'b01;
				ilc_pkg::CLR_CODE_CH1:  clr_sel = 2'b10;
				ilc_pkg::CLR_CODE_BOTH: clr_sel = 2'b11;
				default:                clr_sel = 2'b00;
			endcase
		end
	end

	// One-cycle clear pulse per channel
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clr_pulse <= '0;
		end else begin
			clr_pulse <= clr_sel;
		end
	end
	assign chan_clear_o = clr_pulse;

	// Reserved upper bits of the latch clear register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lcr_rsvd <= ilc_pkg::LCR_RSVD_RST;
		end else if (wr_en && paddr_i == ilc_pkg::OFS_LATCH_CLR) begin
			lcr_rsvd <= pwdata_i[7:ilc_pkg::LCR_RSVD_LSB];
		end
	end

	genvar g;
	generate
		for (g = 0; g < NC; g++) begin : g_ch
			// Software control, untouched by the latch clear
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					ctrl[g] <= '0;
				end else if (wr_ctrl[g]) begin
					ctrl[g].ack_val    <= pwdata_i[ilc_pkg::CTL_ACK_VAL];
					ctrl[g].ack_chk    <= pwdata_i[ilc_pkg::CTL_ACK_CHK];
					ctrl[g].dir_tx     <= pwdata_i[ilc_pkg::CTL_DIR_TX];
					ctrl[g].rx_release <= 1'b0;
				end
			end

			// Ack level sampled from the bus while transmitting
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					ack_sampled[g] <= 1'b0;
				end else if (evt[g].ack_evt) begin
					ack_sampled[g] <= evt[g].ack_lvl;
				end else if (wr_ctrl[g] && !pwdata_i[ilc_pkg::CTL_ACK_CHK]) begin
					ack_sampled[g] <= 1'b0;
				end
			end

			// Receive data ready: set wins over clear
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					rx_ready[g] <= 1'b0;
				end else if (evt[g].rx_done) begin
					rx_ready[g] <= 1'b1;
				end else if (clr_pulse[g]) begin
					rx_ready[g] <= 1'b0;
				end else if (wr_ctrl[g] && pwdata_i[ilc_pkg::CTL_RX_REL]) begin
					rx_ready[g] <= 1'b0;
				end
			end

			ilc_channel u_ch (
				.clock_i  (clock_i),
				.rst_n_i  (rst_n_i),
				.clear_i  (clr_pulse[g]),
				.scl_i    (scl_s[g]),
				.sda_i    (sda_s[g]),
				.ctrl_i   (ctrl[g]),
				.sda_oe_o (sda_oe_o[g]),
				.evt_o    (evt[g])
			);

			assign irq_set[g*ilc_pkg::IRQ_PER_CH + ilc_pkg::IRQ_ACK] = evt[g].ack_evt;
			assign irq_set[g*ilc_pkg::IRQ_PER_CH + ilc_pkg::IRQ_RX]  = evt[g].rx_done;
			assign irq_set[g*ilc_pkg::IRQ_PER_CH + ilc_pkg::IRQ_CLR] = clr_pulse[g];
		end
	endgenerate

	// Open drain: data low only when enabled; clock never held
	assign sda_o    = '0;
	assign scl_o    = '0;
	assign scl_oe_o = '0;

	// Interrupt status, write one to clear, set wins
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_stat <= ilc_pkg::IRQ_RST;
		end else if (wr_en && paddr_i == ilc_pkg::OFS_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~pwdata_i[ilc_pkg::IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_mask <= ilc_pkg::IRQ_RST;
		end else if (wr_en && paddr_i == ilc_pkg::OFS_IRQ_MASK) begin
			irq_mask <= pwdata_i[ilc_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// Read mux
	function automatic logic [31:0] ctrl_word(ilc_pkg::ilc_ctrl_t c, logic samp, logic rdy);
		logic [31:0] w;
		w = '0;
		w[ilc_pkg::CTL_ACK_VAL]  = c.dir_tx ? samp : c.ack_val;
		w[ilc_pkg::CTL_ACK_CHK]  = c.ack_chk;
		w[ilc_pkg::CTL_DIR_TX]   = c.dir_tx;
		w[ilc_pkg::CTL_RX_READY] = rdy;
		return w;
	endfunction : ctrl_word

	always_comb begin
		next_rdata = '0;
		unique case (paddr_i)
			ilc_pkg::OFS_CTRL0:     next_rdata = ctrl_word(ctrl[0], ack_sampled[0], rx_ready[0]);
			ilc_pkg::OFS_CTRL1:     next_rdata = ctrl_word(ctrl[1], ack_sampled[1], rx_ready[1]);
			ilc_pkg::OFS_LATCH_CLR: next_rdata = {24'h0, lcr_rsvd, 1'b0,
				ilc_pkg::CLR_CODE_READ};
			ilc_pkg::OFS_IRQ_STAT:  next_rdata = {26'h0, irq_stat};
			ilc_pkg::OFS_IRQ_MASK:  next_rdata = {26'h0, irq_mask};
			default:                next_rdata = '0;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= '0;
		end else if (rd_setup) begin
			prdata_o <= next_rdata;
		end
	end
endmodule : ilc_top

// >>> logic/ilc_pkg.sv
// Shared constants and carrier types for the two-channel ack and latch clear block.
// Assumes a 32-bit APB slave on a single 20 MHz clock; pins are sampled, not clocked.
// Notes on behaviour
// - In transmit with ack checking on, a high ack from the receiver sets the ack bit.
// - In transmit with ack checking on, a low ack from the receiver clears the ack bit.
// - Writing zero to the ack check enable clears the sampled ack bit read in transmit.
// - In receive, the stored ack bit is driven onto the data line after each byte.
// - Reading the ack bit gives the sampled level in transmit and the written value in receive.
// - Writing the ack bit updates the value returned after reception in either direction.
// - Clear code 0101 clears channel zero, 0110 channel one, 0111 both, others nothing.
// - A valid clear code write initialises the selected channel's internal state.
// - The four clear code bits are write-only, keep nothing and read as one.
// - A channel clear also clears that channel's receive data ready flag.
package ilc_pkg;
	localparam int           NUM_CH        = 2;
	localparam int           ADDR_W        = 8;
	// Register byte offsets
	localparam logic [7:0]   OFS_CTRL0     = 8'h00;
	localparam logic [7:0]   OFS_CTRL1     = 8'h04;
	localparam logic [7:0]   OFS_LATCH_CLR = 8'h08;
	localparam logic [7:0]   OFS_IRQ_STAT  = 8'h0c;
	localparam logic [7:0]   OFS_IRQ_MASK  = 8'h10;
	// Channel control register bit positions
	localparam int           CTL_ACK_VAL   = 0;
	localparam int           CTL_ACK_CHK   = 1;
	localparam int           CTL_DIR_TX    = 2;
	localparam int           CTL_RX_READY  = 3;
	localparam int           CTL_RX_REL    = 4;
	// Latch clear register layout
	localparam int           LCR_RSVD_LSB  = 5;
	localparam logic [3:0]   CLR_CODE_CH0  = 4'h5;
	localparam logic [3:0]   CLR_CODE_CH1  = 4'h6;
	localparam logic [3:0]   CLR_CODE_BOTH = 4'h7;
	localparam logic [3:0]   CLR_CODE_READ = 4'hf;
	localparam logic [2:0]   LCR_RSVD_RST  = 3'h0;
	// Interrupt bits per channel: base is channel * IRQ_PER_CH
	localparam int           IRQ_PER_CH    = 3;
	localparam int           IRQ_ACK       = 0;
	localparam int           IRQ_RX        = 1;
	localparam int           IRQ_CLR       = 2;
	localparam int           IRQ_W         = NUM_CH * IRQ_PER_CH;
	localparam logic [5:0]   IRQ_RST       = 6'h00;
	// Bus clock count: ack clock index, last data bit clock
	localparam logic [3:0]   ACK_CLOCK     = 4'h9;
	localparam logic [3:0]   LAST_DATA_CLK = 4'h8;

	typedef struct packed {
		logic rx_release;
		logic dir_tx;
		logic ack_chk;
		logic ack_val;
	} ilc_ctrl_t;

	typedef struct packed {
		logic ack_evt;
		logic ack_lvl;
		logic rx_done;
	} ilc_evt_t;
endpackage : ilc_pkg

// >>> logic/ilc_sync2.sv
// Two-flop synchroniser for pin levels.
// Assumes inputs come from outside the clock domain.
`timescale 1ns/1ps
module ilc_sync2 #(
	parameter int W = 2
) (
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta   <= '1;
			sync_o <= '1;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule : ilc_sync2

// >>> logic/ilc_channel.sv
// One bus channel: start/stop tracking, clock count, ack capture and ack drive.
// Assumes synchronised clock and data levels; clear_i is a one-cycle pulse.
`timescale 1ns/1ps
module ilc_channel (
	input  wire logic           clock_i,
	input  wire logic           rst_n_i,
	input  wire logic           clear_i,
	input  wire logic           scl_i,
	input  wire logic           sda_i,
	input  wire ilc_pkg::ilc_ctrl_t ctrl_i,
	output logic                sda_oe_o,
	output ilc_pkg::ilc_evt_t   evt_o
);
	logic       scl_d;
	logic       sda_d;
	logic       active;
	logic [3:0] clk_cnt;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;

	assign scl_rise  = scl_i & ~scl_d;
	assign scl_fall  = ~scl_i & scl_d;
	assign start_det = scl_i & scl_d & sda_d & ~sda_i;
	assign stop_det  = scl_i & scl_d & ~sda_d & sda_i;

	// Edge history
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_i;
			sda_d <= sda_i;
		end
	end

	// Frame tracking and clock count
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active  <= 1'b0;
			clk_cnt <= 4'h0;
		end else if (clear_i) begin
			active  <= 1'b0;
			clk_cnt <= 4'h0;
		end else if (start_det) begin
			active  <= 1'b1;
			clk_cnt <= 4'h0;
		end else if (stop_det) begin
			active  <= 1'b0;
			clk_cnt <= 4'h0;
		end else if (active && scl_rise) begin
			clk_cnt <= clk_cnt + 4'h1;
		end else if (active && scl_fall && clk_cnt == ilc_pkg::ACK_CLOCK) begin
			clk_cnt <= 4'h0;
		end
	end

	// Ack drive in receive: open drain low for a zero ack
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_oe_o <= 1'b0;
		end else if (clear_i || stop_det || !active) begin
			sda_oe_o <= 1'b0;
		end else if (scl_fall && clk_cnt == ilc_pkg::LAST_DATA_CLK && !ctrl_i.dir_tx) begin
			sda_oe_o <= ~ctrl_i.ack_val;
		end else if (scl_fall && clk_cnt == ilc_pkg::ACK_CLOCK) begin
			sda_oe_o <= 1'b0;
		end
	end

	// Events at the rise of the ack clock
	always_comb begin
		evt_o.ack_evt = active && scl_rise && clk_cnt == ilc_pkg::LAST_DATA_CLK
			&& ctrl_i.dir_tx && ctrl_i.ack_chk;
		evt_o.ack_lvl = sda_i;
		evt_o.rx_done = active && scl_rise && clk_cnt == ilc_pkg::LAST_DATA_CLK
			&& !ctrl_i.dir_tx;
	end
endmodule : ilc_channel

// >>> bench/ilc_chk.sv
// Concurrent checks on the ack and latch clear block top.
// Assumes APB on clock_i; channel control is mirrored from bus writes.
`timescale 1ns/1ps
module ilc_chk (
	input  wire logic                       clock_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [ilc_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]                pwdata_i,
	input  wire logic [31:0]                prdata_o,
	input  wire logic                       pslverr_o,
	input  wire logic [ilc_pkg::NUM_CH-1:0] sda_oe_o,
	input  wire logic [ilc_pkg::NUM_CH-1:0] chan_clear_o
);
	logic [1:0] ackv;
	logic [1:0] chk;
	logic [1:0] dtx;
	logic [1:0] wr_c;
	logic       acc;
	logic       wr;
	logic       wlc;
	logic       rd0;
	assign acc = psel_i & penable_i;
	assign wr = acc & pwrite_i;
	assign wlc = wr & (paddr_i == ilc_pkg::OFS_LATCH_CLR);
	assign rd0 = acc & !pwrite_i & (paddr_i == ilc_pkg::OFS_CTRL0);
	assign wr_c[0] = wlc & (pwdata_i[3:0] inside {4'h5, 4'h7});
	assign wr_c[1] = wlc & (pwdata_i[3:0] inside {4'h6, 4'h7});
	// Mirror of the written control fields
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ackv <= 2'h0;
			chk <= 2'h0;
			dtx <= 2'h0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (wr && paddr_i == 8'(4 * c)) begin
					ackv[c] <= pwdata_i[ilc_pkg::CTL_ACK_VAL];
					chk[c] <= pwdata_i[ilc_pkg::CTL_ACK_CHK];
					dtx[c] <= pwdata_i[ilc_pkg::CTL_DIR_TX];
				end
			end
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_clr_map; chan_clear_o == $past(wr_c); endproperty
	a_clr_map: assert property (p_clr_map) else $error("clear pulse mismatch");
	property p_clr_pulse; chan_clear_o[0] |=> !chan_clear_o[0]; endproperty
	a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
	property p_lcr_rd; acc && !pwrite_i && paddr_i == 8'h08 |-> prdata_o[4:0] == 5'h0f; endproperty
	a_lcr_rd: assert property (p_lcr_rd) else $error("clear code readback");
	property p_rx_drive; (sda_oe_o & (dtx | ackv)) == 2'h0; endproperty
	a_rx_drive: assert property (p_rx_drive) else $error("ack drive wrong");
	property p_rd_rx; rd0 && !dtx[0] |-> prdata_o[0] == ackv[0]; endproperty
	a_rd_rx: assert property (p_rd_rx) else $error("rx ack read");
	property p_rd_tx; rd0 && dtx[0] && !chk[0] |-> !prdata_o[0]; endproperty
	a_rd_tx: assert property (p_rd_tx) else $error("ack not cleared");
	property p_slverr; acc && paddr_i > 8'h10 |-> pslverr_o; endproperty
	a_slverr: assert property (p_slverr) else $error("no slave error");
	property p_clr_abort; chan_clear_o[1] |=> !sda_oe_o[1]; endproperty
	a_clr_abort: assert property (p_clr_abort) else $error("drive after clear");
endmodule : ilc_chk

bind ilc_top ilc_chk i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pslverr_o(pslverr_o), .sda_oe_o(sda_oe_o),
	.chan_clear_o(chan_clear_o));

// >>> bench/ilc_bus_model.sv
// Far-side bus master clocking one byte plus ack on either channel.
// Open-drain lines with pull-ups; the block pulls data low via sda_oe_i.
`timescale 1ns/1ps
module ilc_bus_model (
	input  wire logic       clock_i,
	input  wire logic [1:0] sda_oe_i,
	output logic      [1:0] scl_o,
	output logic      [1:0] sda_o
);
	logic [1:0] scl_d = 2'h3;
	logic [1:0] sda_d = 2'h3;
	logic       ack_seen = 1'b1;
	assign scl_o = scl_d;
	assign sda_o = sda_d & ~sda_oe_i;
	// Set both lines of a channel, hold n clocks
	task automatic put(input int c, input logic s, input logic d, input int n);
		scl_d[c] <= s;
		sda_d[c] <= d;
		repeat (n) @(posedge clock_i);
	endtask : put
	// Start, eight bits, ack clock at level a, stop; 400 ns period
	task automatic frame(input int c, input logic [7:0] b, input logic a);
		put(c, 1'b1, 1'b0, 4);
		for (int i = 7; i >= 0; i--) begin
			put(c, 1'b0, sda_d[c], 2);
			put(c, 1'b0, b[i], 2);
			put(c, 1'b1, b[i], 4);
		end
		put(c, 1'b0, sda_d[c], 2);
		put(c, 1'b0, a, 2);
		put(c, 1'b1, a, 2);
		ack_seen = sda_o[c];
		put(c, 1'b1, a, 2);
		put(c, 1'b0, a, 2);
		put(c, 1'b0, 1'b0, 2);
		put(c, 1'b1, 1'b0, 4);
		put(c, 1'b1, 1'b1, 4);
	endtask : frame
endmodule : ilc_bus_model

// >>> bench/tb_top.sv
// Self-checking bench for the ack and latch clear block.
// APB master in the bench; bus model on both channel pins.
`timescale 1ns/1ps
module tb_top;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        irq;
	logic [1:0]  scl;
	logic [1:0]  sda;
	logic [1:0]  sda_oe;
	logic [1:0]  clr;
	logic [1:0]  sda_out;
	logic [1:0]  scl_out;
	logic [1:0]  scl_oe;
	logic [1:0]  clr_acc = 2'h0;
	int          err_total = 0;
	int          n_compared = 0;
	always #25 clock = ~clock;
	always @(negedge clock) clr_acc = clr_acc | clr;
	ilc_top i_dut (.clock_i(clock), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
		.sda_oe_o(sda_oe), .scl_o(scl_out), .scl_oe_o(scl_oe), .chan_clear_o(clr), .irq_o(irq));
	ilc_bus_model i_bus (.clock_i(clock), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] e);
		n_compared++;
		if (got !== e) begin
			$display("BAD %s exp %h got %h", nm, e, got);
			err_total++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask : rd
	task automatic look(input logic e);
		repeat (3) @(posedge clock);
		chk("irq", {31'h0, irq}, {31'h0, e});
	endtask : look
	task automatic report_and_stop;
		$display("mismatches %0d of %0d compares", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial begin
		#400000;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd("ctrl0 rst", 8'h00, 32'h0);
		rd("lclr rst", 8'h08, 32'hf);
		rd("hole", 8'h14, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		wr(8'h00, 32'h6);
		i_bus.frame(0, 8'ha5, 1'b1);
		rd("ack hi", 8'h00, 32'h7);
		i_bus.frame(0, 8'h3c, 1'b0);
		rd("ack lo", 8'h00, 32'h6);
		i_bus.frame(0, 8'hc3, 1'b1);
		wr(8'h00, 32'h5);
		rd("chk off", 8'h00, 32'h4);
		wr(8'h00, 32'h1);
		rd("rx val", 8'h00, 32'h1);
		wr(8'h04, 32'h0);
		i_bus.frame(1, 8'h5a, 1'b1);
		chk("ack drv0", {31'h0, i_bus.ack_seen}, 32'h0);
		wr(8'h04, 32'h1);
		i_bus.frame(1, 8'h96, 1'b1);
		chk("ack drv1", {31'h0, i_bus.ack_seen}, 32'h1);
		rd("rx rdy", 8'h04, 32'h9);
		wr(8'h04, 32'h11);
		rd("rx rel", 8'h04, 32'h1);
		i_bus.frame(1, 8'h69, 1'b1);
		rd("stat", 8'h0c, 32'h11);
		wr(8'h10, 32'h10);
		look(1'b1);
		wr(8'h10, 32'h0);
		look(1'b0);
		wr(8'h10, 32'h11);
		wr(8'h0c, 32'h11);
		look(1'b0);
		rd("stat w1c", 8'h0c, 32'h0);
		for (int k = 0; k < 16; k++) begin
			clr_acc = 2'h0;
			wr(8'h08, 32'(k));
			repeat (2) @(posedge clock);
			chk("clear", 32'(clr_acc), k==5 ? 1 : k==6 ? 2 : k==7 ? 3 : 0);
		end
		rd("ch1 clr", 8'h04, 32'h1);
		rd("ch0 kept", 8'h00, 32'h1);
		rd("lclr", 8'h08, 32'hf);
		chk("pins idle", {26'h0, sda_out, scl_out, scl_oe}, 32'h0);
		report_and_stop();
	end
endmodule : tb_top
